// ===== design/tlr_pkg.sv
// Package of register map constants for the temperature limit, slew and identity register bank
package tlr_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   // Register offsets (16-bit registers, word index on the plain port)
   localparam logic [4:0] LOWER_LIMIT_OFS = 5'h05;
   localparam logic [4:0] UPPER_LIMIT_OFS = 5'h06;
   localparam logic [4:0] HYST_OFS = 5'h07;
   localparam logic [4:0] RISE_RATE_OFS = 5'h08;
   localparam logic [4:0] SERIAL_HIGH_OFS = 5'h09;
   localparam logic [4:0] SERIAL_MID_OFS = 5'h0a;
   localparam logic [4:0] SERIAL_LOW_OFS = 5'h0b;
   localparam logic [4:0] PART_ID_OFS = 5'h0c;
   localparam logic [4:0] IRQ_STATUS_OFS = 5'h10;
   localparam logic [4:0] IRQ_ENABLE_OFS = 5'h11;
   localparam logic [4:0] IRQ_CLEAR_OFS = 5'h12;
   localparam logic [4:0] LIMIT_STATE_OFS = 5'h13;
   // Reset values
   localparam logic [15:0] UPPER_LIMIT_RST = 16'h2a80;
   localparam logic [15:0] LOWER_LIMIT_RST = 16'hf380;
   localparam logic [15:0] HYST_RST = 16'h0a0a;
   localparam logic [15:0] RISE_RATE_RST = 16'h0500;
   localparam logic [2:0] IRQ_ENABLE_RST = 3'h0;
   // Field positions
   localparam int LIMIT_MSB = 15;
   localparam int LIMIT_LSB = 2;
   localparam int UHYST_MSB = 15;
   localparam int UHYST_LSB = 8;
   localparam int LHYST_MSB = 7;
   localparam int LHYST_LSB = 0;
   localparam int RATE_MSB = 14;
   localparam int RATE_LSB = 2;
   // Event bits of status, enable and clear
   localparam int EV_HIGH = 0;
   localparam int EV_LOW = 1;
   localparam int EV_SLEW = 2;
   localparam int EV_W = 3;
endpackage

// ===== design/tlr_regs.sv
// Temperature limit, hysteresis, slew threshold and identity register bank
//Function
//- Upper limit is 14-bit two's complement in bits 15:2, 0.03125 C per count.
//- Upper limit resets to 2a80, which is 85 C.
//- Limits ignored while upper limit is not above lower limit.
//- Upper limit bits 1:0 always read zero.
//- Upper hysteresis byte in 15:8; release at upper limit minus it.
//- Lower hysteresis byte in 7:0; release at lower limit plus it.
//- Both hysteresis bytes reset to 0a, register reads 0a0a.
//- Slew threshold is 13-bit unsigned in 14:2; bit 15 and 1:0 read zero.
//- Slew threshold field resets to 0140, register reads 0500.
//- Slew alert only on rising rate above threshold; enable gates it at the irq pin only.
//- Read-only 48-bit serial number over three registers, high word first.
//- Read-only part identity with revision at offset 0c.
//- Lower limit uses same format, resets to f380, used in ordering check.
`timescale 1ns/1ns
module tlr_regs #(
   parameter logic [47:0] SERIAL_NUMBER = 48'h0123_4567_89ab,
   // Arbitrary neutral values
   parameter logic [3:0] REV_CODE = 4'h1,
   parameter logic [11:0] PART_CODE = 12'h0a5
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [tlr_pkg::ADDR_W-1:0] addr_i,
   input wire logic [tlr_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [tlr_pkg::DATA_W-1:0] rdata_o,
   input wire logic conv_done_i,
   input wire logic [13:0] temp_result_i,
   input wire logic [12:0] slew_rate_i,
   input wire logic slew_rising_i,
   output logic [13:0] upper_temp_limit_o,
   output logic [13:0] lower_temp_limit_o,
   output logic limits_valid_o,
   output logic high_status_o,
   output logic low_status_o,
   output logic slew_status_o,
   output logic irq_o
);
   logic [13:0] upper_r;
   logic [13:0] lower_r;
   logic [7:0] uhyst_r;
   logic [7:0] lhyst_r;
   logic [12:0] rate_r;
   logic [2:0] en_r;
   logic [2:0] sts_r;
   logic [2:0] sts_nxt;
   logic high_r;
   logic low_r;
   logic slew_r;
   logic high_nxt;
   logic low_nxt;
   logic slew_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rd_mux;

   // Sign-extend to 15 bits so limit +/- hysteresis never wraps
   function automatic logic signed [14:0] sx(input logic [13:0] v);
      sx = signed'({v[13], v});
   endfunction
   // Hysteresis is 0.5 C per count, i.e. 16 counts of 0.03125 C
   function automatic logic signed [14:0] hx(input logic [7:0] h);
      hx = signed'({3'h0, h, 4'h0});
   endfunction

   wire sel_upper = addr_i == tlr_pkg::UPPER_LIMIT_OFS;
   wire sel_lower = addr_i == tlr_pkg::LOWER_LIMIT_OFS;
   wire sel_hyst = addr_i == tlr_pkg::HYST_OFS;
   wire sel_rate = addr_i == tlr_pkg::RISE_RATE_OFS;
   wire sel_en = addr_i == tlr_pkg::IRQ_ENABLE_OFS;
   wire sel_clr = addr_i == tlr_pkg::IRQ_CLEAR_OFS;

   wire signed [14:0] t_s = sx(temp_result_i);
   wire signed [14:0] hi_s = sx(upper_r);
   wire signed [14:0] lo_s = sx(lower_r);
   wire limits_ok = hi_s > lo_s;
   wire signed [14:0] hi_rel = hi_s - hx(uhyst_r);
   wire signed [14:0] lo_rel = lo_s + hx(lhyst_r);

   // Comparator with hysteresis, evaluated only on a finished conversion
   always_comb begin
      high_nxt = high_r;
      low_nxt = low_r;
      slew_nxt = slew_r;
      if (conv_done_i) begin
         if (!limits_ok) begin
            high_nxt = 1'b0;
            low_nxt = 1'b0;
         end else begin
            if (t_s >= hi_s)
               high_nxt = 1'b1;
            else if (t_s < hi_rel)
               high_nxt = 1'b0;
            if (t_s <= lo_s)
               low_nxt = 1'b1;
            else if (t_s > lo_rel)
               low_nxt = 1'b0;
         end
         // Falling rates never alert
         slew_nxt = slew_rising_i && (slew_rate_i > rate_r);
      end
   end

   // New events set sticky bits; set wins over a same-cycle clear
   wire [2:0] ev = {slew_nxt & ~slew_r, low_nxt & ~low_r, high_nxt & ~high_r};
   wire [2:0] clr = (wr_i && sel_clr) ? wdata_i[2:0] : 3'h0;
   assign sts_nxt = (sts_r & ~clr) | ev;

   assign rd_mux =
      (addr_i == tlr_pkg::UPPER_LIMIT_OFS) ? {upper_r, 2'b00} :
      (addr_i == tlr_pkg::LOWER_LIMIT_OFS) ? {lower_r, 2'b00} :
      (addr_i == tlr_pkg::HYST_OFS) ? {uhyst_r, lhyst_r} :
      (addr_i == tlr_pkg::RISE_RATE_OFS) ? {1'b0, rate_r, 2'b00} :
      (addr_i == tlr_pkg::SERIAL_HIGH_OFS) ? SERIAL_NUMBER[47:32] :
      (addr_i == tlr_pkg::SERIAL_MID_OFS) ? SERIAL_NUMBER[31:16] :
      (addr_i == tlr_pkg::SERIAL_LOW_OFS) ? SERIAL_NUMBER[15:0] :
      (addr_i == tlr_pkg::PART_ID_OFS) ? {REV_CODE, PART_CODE} :
      (addr_i == tlr_pkg::IRQ_STATUS_OFS) ? {13'h0, sts_r} :
      (addr_i == tlr_pkg::IRQ_ENABLE_OFS) ? {13'h0, en_r} :
      (addr_i == tlr_pkg::LIMIT_STATE_OFS) ? {12'h0, limits_ok, slew_r, low_r, high_r} :
      16'h0000;

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         upper_r <= tlr_pkg::UPPER_LIMIT_RST[15:2];
         lower_r <= tlr_pkg::LOWER_LIMIT_RST[15:2];
         uhyst_r <= tlr_pkg::HYST_RST[15:8];
         lhyst_r <= tlr_pkg::HYST_RST[7:0];
         rate_r <= tlr_pkg::RISE_RATE_RST[14:2];
         en_r <= tlr_pkg::IRQ_ENABLE_RST;
      end else if (wr_i) begin
         if (sel_upper)
            upper_r <= wdata_i[15:2];
         if (sel_lower)
            lower_r <= wdata_i[15:2];
         if (sel_hyst) begin
            uhyst_r <= wdata_i[15:8];
            lhyst_r <= wdata_i[7:0];
         end
         if (sel_rate)
            rate_r <= wdata_i[14:2];
         if (sel_en)
            en_r <= wdata_i[2:0];
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         high_r <= 1'b0;
         low_r <= 1'b0;
         slew_r <= 1'b0;
         sts_r <= 3'h0;
         rdata_r <= 16'h0000;
      end else begin
         high_r <= high_nxt;
         low_r <= low_nxt;
         slew_r <= slew_nxt;
         sts_r <= sts_nxt;
         rdata_r <= rd_i ? rd_mux : 16'h0000;
      end
   end

   assign rdata_o = rdata_r;
   assign upper_temp_limit_o = upper_r;
   assign lower_temp_limit_o = lower_r;
   assign limits_valid_o = limits_ok;
   assign high_status_o = high_r;
   assign low_status_o = low_r;
   assign slew_status_o = slew_r;
   // Slew only reaches the pin when enabled
   assign irq_o = |(sts_r & en_r);
endmodule

// ===== bench/tlr_conv_model.sv
// Conversion engine model feeding results to the register bank
`timescale 1ns/1ns
module tlr_conv_model (
   input wire logic core_clk_i,
   output logic conv_done_o,
   output logic [13:0] temp_o,
   output logic [12:0] rate_o,
   output logic rising_o
);
   initial begin
      conv_done_o = 1'b0;
      temp_o = 14'h0000;
      rate_o = 13'h0000;
      rising_o = 1'b0;
   end
   // Result lines invert after the pulse so a stale value never looks valid
   task automatic convert(input logic [13:0] t, input logic [12:0] r, input logic up);
      @(posedge core_clk_i);
      conv_done_o <= 1'b1;
      temp_o <= t;
      rate_o <= r;
      rising_o <= up;
      @(posedge core_clk_i);
      conv_done_o <= 1'b0;
      temp_o <= ~t;
      rate_o <= ~r;
      rising_o <= ~up;
   endtask
endmodule

// ===== bench/tlr_regs_asserts.sv
// Port assertions for the limit and identity register bank
`timescale 1ns/1ns
module tlr_regs_asserts (
   input wire logic core_clk_i, reset_i, wr_i, rd_i, conv_done_i, slew_rising_i,
   input wire logic limits_valid_o, high_status_o, low_status_o, slew_status_o,
   input wire logic [4:0] addr_i,
   input wire logic [15:0] wdata_i, rdata_o,
   input wire logic [13:0] temp_result_i, upper_temp_limit_o, lower_temp_limit_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   chk_upper_write: assert property (wr_i && addr_i == 5'h06 |=>
      upper_temp_limit_o == $past(wdata_i[15:2])) else $error("upper limit not written");
   chk_upper_read: assert property (rd_i && addr_i == 5'h06 |=>
      rdata_o == {$past(upper_temp_limit_o), 2'b00}) else $error("upper limit read wrong");
   chk_rate_zero: assert property (rd_i && addr_i == 5'h08 |=>
      !rdata_o[15] && rdata_o[1:0] == 2'b00) else $error("slew reserved bits set");
   chk_limit_order: assert property (limits_valid_o ==
      ($signed(upper_temp_limit_o) > $signed(lower_temp_limit_o))) else $error("limit order wrong");
   chk_limits_ignored: assert property (conv_done_i && !limits_valid_o |=>
      !high_status_o && !low_status_o) else $error("limits not ignored");
   chk_high_set: assert property (conv_done_i && limits_valid_o &&
      $signed(temp_result_i) >= $signed(upper_temp_limit_o) |=> high_status_o) else $error("high not set");
   chk_low_set: assert property (conv_done_i && limits_valid_o &&
      $signed(temp_result_i) <= $signed(lower_temp_limit_o) |=> low_status_o) else $error("low not set");
   chk_slew_falling: assert property (conv_done_i && !slew_rising_i |=>
      !slew_status_o) else $error("slew set on falling");
   chk_state_hold: assert property (!conv_done_i |=>
      $stable({high_status_o, low_status_o, slew_status_o})) else $error("state moved");
   cover property (conv_done_i ##1 high_status_o);
   cover property (conv_done_i ##1 low_status_o);
   cover property (conv_done_i ##1 slew_status_o);
endmodule
bind tlr_regs tlr_regs_asserts tlr_regs_asserts_i (.*);

// ===== bench/tb_tlr_regs.sv
// Self-checking bench for the limit, slew and identity register bank
`timescale 1ns/1ns
module tb_tlr_regs;
   localparam logic [47:0] SN = 48'h5a5a_c3c3_0f0f; // Arbitrary serial and identity values
   logic core_clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, conv_done_i, slew_rising_i;
   logic limits_valid_o, high_status_o, low_status_o, slew_status_o, irq_o;
   logic [4:0] addr_i = 5'h00;
   logic [15:0] wdata_i = 16'h0000, rdata_o, d;
   logic [13:0] temp_result_i, upper_temp_limit_o, lower_temp_limit_o;
   logic [12:0] slew_rate_i;
   int n_fail = 0, tests_run = 0;
   logic [20:0] rv [9] = '{{5'h05, 16'hf380}, {5'h06, 16'h2a80}, {5'h07, 16'h0a0a}, {5'h08, 16'h0500},
      {5'h09, SN[47:32]}, {5'h0a, SN[31:16]}, {5'h0b, SN[15:0]}, {5'h0c, 16'h30bd}, {5'h1f, 16'h0000}};
   tlr_regs #(.SERIAL_NUMBER(SN), .REV_CODE(4'h3), .PART_CODE(12'h0bd)) tlr_regs_i (.*);
   tlr_conv_model tlr_conv_model_i (.core_clk_i(core_clk_i), .conv_done_o(conv_done_i),
      .temp_o(temp_result_i), .rate_o(slew_rate_i), .rising_o(slew_rising_i));
   initial forever #5 core_clk_i = ~core_clk_i;
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, e);
   endtask
   // Expected bits: irq, slew, low, high
   task automatic st(input logic [3:0] e);
      #1 chk({12'h000, irq_o, slew_status_o, low_status_o, high_status_o}, {12'h000, e});
   endtask
   task automatic cv(input logic [13:0] t, input logic [12:0] r, input logic up, input logic [3:0] e);
      tlr_conv_model_i.convert(t, r, up);
      st(e);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge core_clk_i);
      n_fail++;
      report_and_stop;
   end
   initial begin
      void'($urandom(95));
      repeat (8) @(posedge core_clk_i);
      reset_i <= 1'b0;
      // Second pass runs after writes to the serial number and part identity words
      repeat (2) begin
         foreach (rv[i]) rd(rv[i][20:16], rv[i][15:0]);
         for (int a = 9; a <= 12; a++) wr(a[4:0], 16'($urandom));
      end
      for (int k = 0; k < 3; k++) begin
         d = (k == 0) ? 16'hffff : 16'($urandom);
         wr(5'h06, d);
         rd(5'h06, d & 16'hfffc);
         wr(5'h07, d);
         rd(5'h07, d);
         wr(5'h08, d);
         rd(5'h08, d & 16'h7ffc);
      end
      wr(5'h05, 16'h2a83);
      rd(5'h05, 16'h2a80);
      wr(5'h05, 16'hf380);
      wr(5'h07, 16'h0a0a);
      wr(5'h08, 16'h0500);
      rd(5'h11, 16'h0000);
      wr(5'h11, 16'h0007);
      wr(5'h06, 16'hf380);
      cv(14'h1fff, 13'h0000, 1'b0, 4'h0);
      wr(5'h06, 16'h2a80);
      cv(14'h0aa0, 13'h0000, 1'b0, 4'h9);
      rd(5'h10, 16'h0001);
      rd(5'h13, 16'h0009);
      cv(14'h0a00, 13'h0000, 1'b0, 4'h9);
      cv(14'h09ff, 13'h0000, 1'b0, 4'h8);
      wr(5'h12, 16'h0001);
      st(4'h0);
      rd(5'h10, 16'h0000);
      rd(5'h12, 16'h0000);
      cv(14'h3ce0, 13'h0000, 1'b0, 4'ha);
      cv(14'h3d80, 13'h0000, 1'b0, 4'ha);
      cv(14'h3d81, 13'h0000, 1'b0, 4'h8);
      wr(5'h11, 16'h0000);
      st(4'h0);
      wr(5'h12, 16'h0007);
      wr(5'h11, 16'h0007);
      cv(14'h0000, 13'h0141, 1'b1, 4'hc);
      cv(14'h0000, 13'h0141, 1'b0, 4'h8);
      cv(14'h0000, 13'h0140, 1'b1, 4'h8);
      rd(5'h10, 16'h0004);
      rd(5'h11, 16'h0007);
      report_and_stop;
   end
endmodule
